/* File: utn_pkg.sv */
package utn_pkg;

    // ------------------------------------------------------------
    // Tone-null mask geometry
    // ------------------------------------------------------------
    localparam int MASK_LEN = 384;
    localparam int BAND_TONES = 128;
    localparam logic [1:0] BAND_LOW = 2'h0;
    localparam logic [1:0] BAND_MID = 2'h1;
    localparam logic [1:0] BAND_HIGH = 2'h2;
    localparam logic [2:0] BAND_SET_TWO = 3'h3;
    localparam logic [2:0] BAND_SET_THREE = 3'h7;
    localparam logic [MASK_LEN-1:0] MASK_RESET = {MASK_LEN{1'b1}};

    // ------------------------------------------------------------
    // Useful bins: data, pilot and sync content sit on +1..+56 and -56..-1
    // ------------------------------------------------------------
    localparam logic [6:0] USE_POS_LO = 7'h01;
    localparam logic [6:0] USE_POS_HI = 7'h38;
    localparam logic [6:0] USE_NEG_LO = 7'h48;
    localparam logic [7:0] MIN_USEFUL = 8'h56;

    // ------------------------------------------------------------
    // Symbol timing in samples
    // ------------------------------------------------------------
    localparam logic [7:0] FFT_LEN = 8'h80;
    localparam logic [7:0] ZPS_LEN = 8'h25;
    localparam logic [7:0] SYM_LAST = FFT_LEN + ZPS_LEN - 8'h01;

    // ------------------------------------------------------------
    // Packet section lengths in symbols
    // ------------------------------------------------------------
    localparam logic [15:0] PRE_STD_SYMS = 16'h001e;
    localparam logic [15:0] PRE_BURST_SYMS = 16'h0012;
    localparam logic [15:0] HDR_SYMS = 16'h000c;

    // ------------------------------------------------------------
    // Section and rate codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEC_NONE = 2'h0,
        SEC_PRE = 2'h1,
        SEC_HDR = 2'h2,
        SEC_PAY = 2'h3
    } utn_section_type;

    localparam logic [3:0] RATE_HDR = 4'h8;
    localparam logic [2:0] RATE_MAX = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PRE = 4'b0010,
        ST_HDR = 4'b0100,
        ST_PAY = 4'b1000
    } utn_state_type;

endpackage

/* File: utn_frame_tone_null.sv */
`timescale 1ns/100ps
module utn_frame_tone_null
    import utn_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic CE_I,
    // Mask configuration
    input wire logic MASK_WR_I,
    input wire logic [8:0] MASK_ADDR_I,
    input wire logic MASK_DATA_I,
    input wire logic [127:0] EXTRA_KEEP_I,
    input wire logic THREE_BANDS_I,
    input wire logic [2:0] BAND_EN_I,
    // Packet request from the MAC side
    input wire logic START_I,
    input wire logic BURST_MODE_I,
    input wire logic [2:0] RATE_I,
    input wire logic [15:0] PAYLOAD_SYMS_I,
    output logic START_READY_O,
    output logic START_REFUSED_O,
    output logic PKT_ACTIVE_O,
    output logic [2:0] BAND_OK_O,
    // Frequency-domain tones in
    input wire logic TONE_VALID_I,
    input wire logic [15:0] TONE_RE_I,
    input wire logic [15:0] TONE_IM_I,
    output logic TONE_READY_O,
    output logic [1:0] TONE_SECTION_O,
    // Bins towards the transform
    input wire logic BIN_READY_I,
    output logic BIN_VALID_O,
    output logic [15:0] BIN_RE_O,
    output logic [15:0] BIN_IM_O,
    output logic [7:0] BIN_IDX_O,
    output logic ZERO_PAD_O,
    output logic [1:0] BAND_O,
    output logic [1:0] SECTION_O,
    output logic [3:0] RATE_O,
    output logic PKT_LAST_O,
    // Octet serialiser
    input wire logic OCTET_VALID_I,
    input wire logic [7:0] OCTET_I,
    output logic OCTET_READY_O,
    input wire logic BIT_READY_I,
    output logic BIT_VALID_O,
    output logic BIT_O
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic bin_useful(input logic [6:0] k);
        bin_useful = ((k >= USE_POS_LO) && (k <= USE_POS_HI)) || (k >= USE_NEG_LO);
    endfunction

    function automatic logic [7:0] count_useful(input logic [127:0] m);
        logic [7:0] c;
        c = 8'h00;
        for (int k = 0; k < BAND_TONES; k++) begin
            if (m[k] && bin_useful(7'(k))) begin
                c = c + 8'h01;
            end
        end
        count_useful = c;
    endfunction

    // Rotate to the next band of the active set, wrapping round
    function automatic logic [1:0] next_band(input logic [1:0] cur, input logic [2:0] act);
        logic [1:0] b;
        logic found;
        b = cur;
        found = 1'b0;
        for (int s = 1; s <= 3; s++) begin
            if (!found && act[(int'(cur) + s) % 3]) begin
                b = 2'((int'(cur) + s) % 3);
                found = 1'b1;
            end
        end
        next_band = b;
    endfunction

    function automatic logic [1:0] first_band(input logic [2:0] act);
        first_band = act[0] ? BAND_LOW : (act[1] ? BAND_MID : BAND_HIGH);
    endfunction

    // ------------------------------------------------------------
    // Mask store and band check
    // ------------------------------------------------------------
    logic [MASK_LEN-1:0] mask_q, mask_d;
    logic [MASK_LEN-1:0] pkt_mask_q, pkt_mask_d;
    logic [MASK_LEN-1:0] eff_mask;
    logic [2:0] band_ok_q, band_ok_d;
    logic [2:0] present;
    logic [2:0] active;

    assign present = THREE_BANDS_I ? BAND_SET_THREE : BAND_SET_TWO;
    // Extra nulling joins the mask before the registered count, so it starves no band unless it changes in the cycle a start is taken
    assign eff_mask = mask_q & {3{EXTRA_KEEP_I}};
    // Only bands that exist, are wanted and pass the count are used
    assign active = band_ok_q & BAND_EN_I & present;

    always_comb begin
        mask_d = mask_q;
        if (MASK_WR_I && (int'(MASK_ADDR_I) < MASK_LEN)) begin
            mask_d[MASK_ADDR_I] = MASK_DATA_I;
        end
    end

    // Band b owns mask slice b*128 .. b*128+127
    generate
        for (genvar b = 0; b < 3; b++) begin : g_band_check
            always_comb begin
                band_ok_d[b] = (count_useful(eff_mask[b*BAND_TONES +: BAND_TONES])
                               >= MIN_USEFUL);
            end
        end
    endgenerate

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            mask_q <= MASK_RESET;
            band_ok_q <= 3'h0;
        end else if (CE_I) begin
            mask_q <= mask_d;
            band_ok_q <= band_ok_d;
        end
    end

    // ------------------------------------------------------------
    // Packet sequencer
    // ------------------------------------------------------------
    utn_state_type state_q, state_d;
    logic [15:0] sec_cnt_q, sec_cnt_d;
    logic [15:0] pre_len_q, pre_len_d;
    logic [15:0] pay_len_q, pay_len_d;
    logic [2:0] rate_q, rate_d;
    logic [2:0] act_q, act_d;
    logic [1:0] band_q, band_d;
    logic [7:0] bin_q, bin_d;
    logic refused_q, refused_d;
    logic out_valid_q, out_valid_d;
    logic running;
    logic in_fft;
    logic take;
    logic sym_end;
    logic sec_end;
    logic [15:0] sec_len;
    utn_section_type section;

    assign running = (state_q != ST_IDLE);
    assign in_fft = (bin_q < FFT_LEN);
    // A slot moves on when the output register is free and, inside the
    // transform block, a tone is available; the suffix needs no input
    assign take = running && (!out_valid_q || BIN_READY_I) && (!in_fft || TONE_VALID_I);
    assign sym_end = take && (bin_q == SYM_LAST);
    assign sec_end = sym_end && (sec_cnt_q == sec_len - 16'h0001);

    always_comb begin
        unique case (state_q)
            ST_PRE: begin
                section = SEC_PRE;
                sec_len = pre_len_q;
            end
            ST_HDR: begin
                section = SEC_HDR;
                sec_len = HDR_SYMS;
            end
            ST_PAY: begin
                section = SEC_PAY;
                sec_len = pay_len_q;
            end
            default: begin
                section = SEC_NONE;
                sec_len = 16'h0000;
            end
        endcase
    end

    always_comb begin
        state_d = state_q;
        sec_cnt_d = sec_cnt_q;
        pre_len_d = pre_len_q;
        pay_len_d = pay_len_q;
        rate_d = rate_q;
        act_d = act_q;
        band_d = band_q;
        bin_d = bin_q;
        pkt_mask_d = pkt_mask_q;
        refused_d = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (START_I) begin
                    if (active == 3'h0) begin
                        refused_d = 1'b1;
                    end else begin
                        // Snapshot mask and band set so mid-packet writes wait
                        pkt_mask_d = eff_mask;
                        act_d = active;
                        band_d = first_band(active);
                        pre_len_d = BURST_MODE_I ? PRE_BURST_SYMS : PRE_STD_SYMS;
                        pay_len_d = PAYLOAD_SYMS_I;
                        rate_d = (RATE_I > RATE_MAX) ? RATE_MAX : RATE_I;
                        sec_cnt_d = 16'h0000;
                        bin_d = 8'h00;
                        state_d = ST_PRE;
                    end
                end
            end
            ST_PRE, ST_HDR, ST_PAY: begin
                if (take) begin
                    bin_d = sym_end ? 8'h00 : bin_q + 8'h01;
                end
                if (sym_end) begin
                    band_d = next_band(band_q, act_q);
                    sec_cnt_d = sec_end ? 16'h0000 : sec_cnt_q + 16'h0001;
                end
                if (sec_end) begin
                    if (state_q == ST_PRE) begin
                        state_d = ST_HDR;
                    end else if (state_q == ST_HDR && pay_len_q != 16'h0000) begin
                        state_d = ST_PAY;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            state_q <= ST_IDLE;
            sec_cnt_q <= 16'h0000;
            pre_len_q <= PRE_STD_SYMS;
            pay_len_q <= 16'h0000;
            rate_q <= 3'h0;
            act_q <= 3'h0;
            band_q <= BAND_LOW;
            bin_q <= 8'h00;
            pkt_mask_q <= MASK_RESET;
            refused_q <= 1'b0;
        end else if (CE_I) begin
            state_q <= state_d;
            sec_cnt_q <= sec_cnt_d;
            pre_len_q <= pre_len_d;
            pay_len_q <= pay_len_d;
            rate_q <= rate_d;
            act_q <= act_d;
            band_q <= band_d;
            bin_q <= bin_d;
            pkt_mask_q <= pkt_mask_d;
            refused_q <= refused_d;
        end
    end

    // ------------------------------------------------------------
    // Output bin register
    // ------------------------------------------------------------
    logic [15:0] out_re_q, out_re_d;
    logic [15:0] out_im_q, out_im_d;
    logic [7:0] out_idx_q, out_idx_d;
    logic out_zps_q, out_zps_d;
    logic [1:0] out_band_q, out_band_d;
    logic [1:0] out_sec_q, out_sec_d;
    logic [3:0] out_rate_q, out_rate_d;
    logic out_last_q, out_last_d;
    logic keep;

    // Same gate for every section: sync symbols go through the same bins
    assign keep = pkt_mask_q[{band_q, bin_q[6:0]}];

    always_comb begin
        out_valid_d = out_valid_q;
        out_re_d = out_re_q;
        out_im_d = out_im_q;
        out_idx_d = out_idx_q;
        out_zps_d = out_zps_q;
        out_band_d = out_band_q;
        out_sec_d = out_sec_q;
        out_rate_d = out_rate_q;
        out_last_d = out_last_q;
        if (out_valid_q && BIN_READY_I) begin
            out_valid_d = 1'b0;
        end
        if (take) begin
            out_valid_d = 1'b1;
            if (in_fft && keep) begin
                out_re_d = TONE_RE_I;
                out_im_d = TONE_IM_I;
            end else begin
                // Nulled bins and the guard suffix both carry zero
                out_re_d = 16'h0000;
                out_im_d = 16'h0000;
            end
            out_idx_d = bin_q;
            out_zps_d = !in_fft;
            out_band_d = band_q;
            out_sec_d = section;
            // Header is always at the fixed lowest rate
            out_rate_d = (state_q == ST_HDR) ? RATE_HDR : {1'b0, rate_q};
            out_last_d = sec_end && (state_d == ST_IDLE);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            out_valid_q <= 1'b0;
            out_re_q <= 16'h0000;
            out_im_q <= 16'h0000;
            out_idx_q <= 8'h00;
            out_zps_q <= 1'b0;
            out_band_q <= BAND_LOW;
            out_sec_q <= SEC_NONE;
            out_rate_q <= 4'h0;
            out_last_q <= 1'b0;
        end else if (CE_I) begin
            out_valid_q <= out_valid_d;
            out_re_q <= out_re_d;
            out_im_q <= out_im_d;
            out_idx_q <= out_idx_d;
            out_zps_q <= out_zps_d;
            out_band_q <= out_band_d;
            out_sec_q <= out_sec_d;
            out_rate_q <= out_rate_d;
            out_last_q <= out_last_d;
        end
    end

    // ------------------------------------------------------------
    // Octet serialiser
    // ------------------------------------------------------------
    // Header and payload fields (check sequences, tail, parity, pad) arrive
    // already ordered from upstream; this stage only fixes the bit order.
    logic [7:0] shift_q, shift_d;
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic busy_q, busy_d;

    always_comb begin
        shift_d = shift_q;
        bit_cnt_d = bit_cnt_q;
        busy_d = busy_q;
        if (busy_q && BIT_READY_I) begin
            shift_d = {1'b0, shift_q[7:1]};
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == BIT_LAST) begin
                busy_d = 1'b0;
            end
        end
        if (!busy_q && OCTET_VALID_I) begin
            shift_d = OCTET_I;
            bit_cnt_d = 3'h0;
            busy_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            shift_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            busy_q <= 1'b0;
        end else if (CE_I) begin
            shift_q <= shift_d;
            bit_cnt_q <= bit_cnt_d;
            busy_q <= busy_d;
        end
    end

    // ------------------------------------------------------------
    // Port drive
    // ------------------------------------------------------------
    assign START_READY_O = !running;
    assign START_REFUSED_O = refused_q;
    assign PKT_ACTIVE_O = running;
    assign BAND_OK_O = band_ok_q;
    assign TONE_READY_O = running && in_fft && (!out_valid_q || BIN_READY_I) && CE_I;
    assign TONE_SECTION_O = section;
    assign BIN_VALID_O = out_valid_q;
    assign BIN_RE_O = out_re_q;
    assign BIN_IM_O = out_im_q;
    assign BIN_IDX_O = out_idx_q;
    assign ZERO_PAD_O = out_zps_q;
    assign BAND_O = out_band_q;
    assign SECTION_O = out_sec_q;
    assign RATE_O = out_rate_q;
    assign PKT_LAST_O = out_last_q;
    assign OCTET_READY_O = !busy_q;
    assign BIT_VALID_O = busy_q;
    assign BIT_O = shift_q[0];

endmodule

/* File: utn_frame_tone_null_assertions.sv */
`timescale 1ns/100ps
module utn_chk
    import utn_pkg::*;
(
    // Clock, reset and start
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic CE_I,
    input wire logic START_I,
    input wire logic START_READY_O,
    input wire logic START_REFUSED_O,
    input wire logic PKT_ACTIVE_O,
    // Bin stream
    input wire logic BIN_READY_I,
    input wire logic BIN_VALID_O,
    input wire logic [15:0] BIN_RE_O,
    input wire logic [15:0] BIN_IM_O,
    input wire logic [7:0] BIN_IDX_O,
    input wire logic ZERO_PAD_O,
    input wire logic [1:0] SECTION_O,
    input wire logic [3:0] RATE_O,
    // Serialiser
    input wire logic OCTET_VALID_I,
    input wire logic [7:0] OCTET_I,
    input wire logic OCTET_READY_O,
    input wire logic BIT_VALID_O,
    input wire logic BIT_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    // ------------------------------------------------------------
    // Start and symbol framing
    // ------------------------------------------------------------
    chk_start_answer: assert property (
        START_I && START_READY_O && CE_I |=> PKT_ACTIVE_O != START_REFUSED_O)
        else $error("start not answered");
    chk_pad_zero: assert property (
        BIN_VALID_O && ZERO_PAD_O |-> BIN_RE_O == 16'h0000 && BIN_IM_O == 16'h0000)
        else $error("suffix sample not zero");
    chk_pad_slots: assert property (
        BIN_VALID_O |-> BIN_IDX_O <= SYM_LAST && ZERO_PAD_O == (BIN_IDX_O >= FFT_LEN))
        else $error("suffix slot wrong");
    chk_slot_step: assert property (
        BIN_VALID_O && BIN_READY_I && CE_I && BIN_IDX_O != SYM_LAST
        |=> !BIN_VALID_O || BIN_IDX_O == $past(BIN_IDX_O) + 8'h01)
        else $error("slot skipped");
    chk_bin_hold: assert property (
        BIN_VALID_O && !BIN_READY_I |=> BIN_VALID_O && $stable(BIN_IDX_O) && $stable(BIN_RE_O))
        else $error("bin dropped under stall");
    chk_sect_order: assert property (
        BIN_VALID_O && PKT_ACTIVE_O ##1 BIN_VALID_O && PKT_ACTIVE_O
        |-> SECTION_O >= $past(SECTION_O))
        else $error("section went back");
    chk_hdr_rate: assert property (
        BIN_VALID_O && SECTION_O == SEC_HDR |-> RATE_O == RATE_HDR)
        else $error("header rate wrong");
    // ------------------------------------------------------------
    // Serialiser
    // ------------------------------------------------------------
    chk_lsb_first: assert property (
        OCTET_VALID_I && OCTET_READY_O && CE_I |=> BIT_VALID_O && BIT_O == $past(OCTET_I[0]))
        else $error("first bit not lsb");

    cov_refused: cover property (START_REFUSED_O);
    cov_stall: cover property (BIN_VALID_O && !BIN_READY_I);
    cov_octet: cover property (OCTET_VALID_I && OCTET_READY_O);
endmodule

bind utn_frame_tone_null utn_chk u_chk (.CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I),
    .START_I(START_I), .START_READY_O(START_READY_O), .START_REFUSED_O(START_REFUSED_O),
    .PKT_ACTIVE_O(PKT_ACTIVE_O), .BIN_READY_I(BIN_READY_I), .BIN_VALID_O(BIN_VALID_O),
    .BIN_RE_O(BIN_RE_O), .BIN_IM_O(BIN_IM_O), .BIN_IDX_O(BIN_IDX_O), .ZERO_PAD_O(ZERO_PAD_O),
    .SECTION_O(SECTION_O), .RATE_O(RATE_O), .OCTET_VALID_I(OCTET_VALID_I), .OCTET_I(OCTET_I),
    .OCTET_READY_O(OCTET_READY_O), .BIT_VALID_O(BIT_VALID_O), .BIT_O(BIT_O));

/* File: utn_bin_sink.sv */
`timescale 1ns/100ps
module utn_bin_sink
    import utn_pkg::*;
#(
    parameter logic [15:0] KEEP_RE = 16'h1234,
    parameter logic [15:0] KEEP_IM = 16'h0567
)
(
    // Clock and control
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic stall_i,
    input wire logic [3:0] exp_rate_i,
    // Bins from the framer
    input wire logic valid_i,
    input wire logic [15:0] re_i,
    input wire logic [15:0] im_i,
    input wire logic [7:0] idx_i,
    input wire logic pad_i,
    input wire logic [1:0] band_i,
    input wire logic [1:0] sec_i,
    input wire logic [3:0] rate_i,
    input wire logic last_i,
    // Ready and tallies
    output logic ready_o,
    output int sec_o [4],
    output int band_o [4],
    output int zero_o [4],
    output int bad_o,
    output int last_o
);
    logic [2:0] cnt_q = 3'h0;
    logic open_q = 1'b0;

    // ------------------------------------------------------------
    // Four cycles open, four stalled, so held bins are exercised
    // ------------------------------------------------------------
    assign ready_o = open_q;
    always @(negedge clk_i) begin
        cnt_q <= cnt_q + 3'h1;
        open_q <= !stall_i || cnt_q[2];
    end

    always @(posedge clk_i) begin
        if (clr_i) begin
            sec_o <= '{default: 0};
            band_o <= '{default: 0};
            zero_o <= '{default: 0};
            bad_o <= 0;
            last_o <= 0;
        end else if (valid_i && ready_o) begin
            if (idx_i == SYM_LAST) begin
                sec_o[sec_i] <= sec_o[sec_i] + 1;
                band_o[band_i] <= band_o[band_i] + 1;
            end
            if (!pad_i && re_i == 16'h0000 && im_i == 16'h0000) begin
                zero_o[sec_i] <= zero_o[sec_i] + 1;
            end
            bad_o <= bad_o
                + int'(!pad_i && re_i != 16'h0000 && (re_i !== KEEP_RE || im_i !== KEEP_IM))
                + int'(sec_i == SEC_PAY && rate_i !== exp_rate_i);
            last_o <= last_o + int'(last_i);
        end
    end
endmodule

/* File: utn_frame_tone_null_tb_top.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module utn_frame_tone_null_tb_top;
    import utn_pkg::*;
    int n_errors = 0;
    int checked = 0;
    int sec [4];
    int band_n [4];
    int zero [4];
    int bad, last_n;
    logic clk, rst, ce, mask_wr, mask_data, three_bands, start, burst, took, gap, stall, clr;
    logic tone_valid, tone_ready, bin_ready, bin_valid, zero_pad, pkt_last, start_ready;
    logic start_refused, pkt_active, octet_valid, octet_ready, bit_ready, bit_valid, bit_o;
    logic [8:0] mask_addr;
    logic [127:0] extra_keep;
    logic [2:0] band_en, rate, band_ok;
    logic [15:0] pay_syms, tone_re, tone_im, bin_re, bin_im;
    logic [7:0] bin_idx, octet;
    logic [1:0] band, section, tone_section;
    logic [3:0] rate_o;

    utn_frame_tone_null u_utn_frame_tone_null (.CLK_I(clk), .RESET_I(rst), .CE_I(ce),
        .MASK_WR_I(mask_wr), .MASK_ADDR_I(mask_addr), .MASK_DATA_I(mask_data),
        .EXTRA_KEEP_I(extra_keep), .THREE_BANDS_I(three_bands), .BAND_EN_I(band_en),
        .START_I(start), .BURST_MODE_I(burst), .RATE_I(rate), .PAYLOAD_SYMS_I(pay_syms),
        .START_READY_O(start_ready), .START_REFUSED_O(start_refused), .PKT_ACTIVE_O(pkt_active),
        .BAND_OK_O(band_ok), .TONE_VALID_I(tone_valid), .TONE_RE_I(tone_re), .TONE_IM_I(tone_im),
        .TONE_READY_O(tone_ready), .TONE_SECTION_O(tone_section), .BIN_READY_I(bin_ready),
        .BIN_VALID_O(bin_valid), .BIN_RE_O(bin_re), .BIN_IM_O(bin_im), .BIN_IDX_O(bin_idx),
        .ZERO_PAD_O(zero_pad), .BAND_O(band), .SECTION_O(section), .RATE_O(rate_o),
        .PKT_LAST_O(pkt_last), .OCTET_VALID_I(octet_valid), .OCTET_I(octet),
        .OCTET_READY_O(octet_ready), .BIT_READY_I(bit_ready), .BIT_VALID_O(bit_valid),
        .BIT_O(bit_o));

    utn_bin_sink u_utn_bin_sink (.clk_i(clk), .clr_i(clr), .stall_i(stall),
        .exp_rate_i({1'b0, rate}), .valid_i(bin_valid), .re_i(bin_re), .im_i(bin_im),
        .idx_i(bin_idx), .pad_i(zero_pad), .band_i(band), .sec_i(section), .rate_i(rate_o),
        .last_i(pkt_last), .ready_o(bin_ready), .sec_o(sec), .band_o(band_n), .zero_o(zero),
        .bad_o(bad), .last_o(last_n));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Tone source drops valid for one cycle after each take when gapping
    always @(posedge clk) took <= tone_valid && tone_ready;
    always @(negedge clk) tone_valid <= !gap || !took;

    task automatic end_of_test;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr_mask(input int lo, input int hi, input logic d);
        @(negedge clk);
        mask_wr = 1'b1;
        mask_data = d;
        for (int a = lo; a <= hi; a++) begin
            mask_addr = 9'(a);
            @(negedge clk);
        end
        mask_wr = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic start_pkt(input logic b, input logic [2:0] r, input logic [15:0] n,
        input logic [2:0] en);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        burst = b;
        rate = r;
        pay_syms = n;
        band_en = en;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    endtask

    task automatic finish_pkt(input int p, input int h, input int y, input int b0, input int b1,
        input int b2);
        int i;
        for (i = 0; i < 40000 && pkt_active !== 1'b0; i++) @(negedge clk);
        // The final bin is still in the output register when the packet drops
        for (i = 0; i < 16 && bin_valid !== 1'b0; i++) @(negedge clk);
        if (pkt_active !== 1'b0 || bin_valid !== 1'b0) begin
            n_errors++;
            end_of_test();
        end
        `CHK(sec[SEC_PRE], p)
        `CHK(sec[SEC_HDR], h)
        `CHK(sec[SEC_PAY], y)
        `CHK(band_n[0], b0)
        `CHK(band_n[1], b1)
        `CHK(band_n[2], b2)
        `CHK(last_n, 1)
        `CHK(bad, 0)
    endtask

    task automatic t_min_tones;
        wr_mask(1, 26, 1'b0);
        `CHK(band_ok, 3'h7)
        wr_mask(27, 27, 1'b0);
        `CHK(band_ok, 3'h6)
        start_pkt(1'b0, 3'h0, 16'h0000, 3'h1);
        `CHK(start_refused, 1'b1)
        `CHK(pkt_active, 1'b0)
        start_pkt(1'b0, 3'h0, 16'h0000, 3'h3);
        `CHK(pkt_active, 1'b1)
        `CHK(tone_section, SEC_PRE)
        finish_pkt(30, 12, 0, 0, 42, 0);
        `CHK(zero[SEC_PRE] + zero[SEC_HDR], 0)
        wr_mask(1, 27, 1'b1);
    endtask

    // Mask and extra nulls change mid-packet; the packet keeps its snapshot
    task automatic t_null_pkt;
        wr_mask(133, 133, 1'b0);
        extra_keep[10] = 1'b0;
        gap = 1'b1;
        stall = 1'b1;
        start_pkt(1'b1, 3'h3, 16'h0002, 3'h3);
        repeat (2000) @(negedge clk);
        extra_keep = '1;
        wr_mask(134, 134, 1'b0);
        finish_pkt(18, 12, 2, 16, 16, 0);
        `CHK(zero[SEC_PRE], 27)
        `CHK(zero[SEC_HDR], 18)
        `CHK(zero[SEC_PAY], 3)
        gap = 1'b0;
        stall = 1'b0;
        wr_mask(133, 134, 1'b1);
    endtask

    task automatic t_serial;
        logic [7:0] v [2] = '{8'hb4, 8'h61};
        logic [7:0] got;
        int i, n;
        foreach (v[k]) begin
            octet_valid = 1'b1;
            octet = v[k];
            for (i = 0; i < 40 && octet_ready !== 1'b1; i++) @(negedge clk);
            @(negedge clk);
            octet_valid = 1'b0;
            `CHK(octet_ready, 1'b0)
            got = 8'h00;
            n = 0;
            for (i = 0; i < 100 && n < 8; i++) begin
                bit_ready = i[0];
                if (bit_valid === 1'b1 && bit_ready) begin
                    got = {bit_o, got[7:1]};
                    n++;
                end
                @(negedge clk);
            end
            bit_ready = 1'b0;
            `CHK(got, v[k])
        end
    endtask

    initial begin
        {rst, ce, three_bands} = 3'h7;
        {mask_wr, mask_data, start, burst, gap, stall, clr} = 7'h00;
        {octet_valid, bit_ready} = 2'h0;
        mask_addr = 9'h000;
        extra_keep = '1;
        band_en = 3'h0;
        rate = 3'h0;
        pay_syms = 16'h0000;
        tone_re = 16'h1234;
        tone_im = 16'h0567;
        octet = 8'h00;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        `CHK({start_ready, octet_ready, pkt_active}, 3'h6)
        `CHK(band_ok, 3'h7)
        t_min_tones();
        t_null_pkt();
        for (int r = 0; r < 8; r++) begin
            start_pkt(1'b1, 3'(r), 16'h0001, 3'h7);
            finish_pkt(18, 12, 1, 11, 10, 10);
        end
        t_serial();
        end_of_test();
    end
endmodule
